// ### src/pin_port_pkg.sv
// Constants for the serial pin port control block.
// Assumes an 8-bit register port and three pins: clock, data out, data in.
package pin_port_pkg;
  localparam int NUM_PINS = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 2;

  // Pin positions inside every per-pin register
  localparam int PIN_CLK = 0;
  localparam int PIN_DOUT = 1;
  localparam int PIN_DIN = 2;

  // Register offsets
  localparam logic [7:0] ADDR_DIR = 8'h00;
  localparam logic [7:0] ADDR_OUT_VALUE = 8'h04;
  localparam logic [7:0] ADDR_IBUF = 8'h08;
  localparam logic [7:0] ADDR_PULLUP = 8'h0c;
  localparam logic [7:0] ADDR_STAGE = 8'h10;
  localparam logic [7:0] ADDR_FUNCTION = 8'h14;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h18;
  localparam logic [7:0] ADDR_RX_DATA = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // Function register: bit 0 pin set select, bits 1..3 clock, data out, data in
  localparam int FN_PIN_LSB = 1;
  localparam int FN_SET_SELECT = 0;

  // Interrupt status bits
  localparam int IRQ_RX_READY = 0;
  localparam int IRQ_OVERRUN = 1;

  // Reset values; output value resets high so a pin leaves input mode high
  localparam logic [2:0] DIR_RST = 3'h0;
  localparam logic [2:0] OUT_VALUE_RST = 3'h7;
  localparam logic [2:0] IBUF_RST = 3'h0;
  localparam logic [2:0] PULLUP_RST = 3'h0;
  localparam logic [2:0] STAGE_RST = 3'h0;
  localparam logic [7:0] FUNCTION_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Port codes: 0..9 then A..G
  localparam logic [4:0] PORT_3 = 5'h03;
  localparam logic [4:0] PORT_9 = 5'h09;
  localparam logic [4:0] PORT_A = 5'h0a;
  localparam logic [4:0] PORT_C = 5'h0c;
  localparam logic [4:0] PORT_E = 5'h0e;
  localparam logic [4:0] PORT_G = 5'h10;

  function automatic logic has_pullup(input logic [4:0] code);
    return (code == PORT_9) || ((code >= PORT_A) && (code <= PORT_E)) || (code == PORT_G);
  endfunction

  function automatic logic has_stage_select(input logic [4:0] code);
    return (code <= PORT_3) || (code == PORT_C);
  endfunction
endpackage

// ### src/rx_word_if.sv
// Link between the pin port top and its receive word holder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rx_word_if #(parameter int W = 8) ();
  logic [W-1:0] word;
  logic word_valid;
  logic pop;
  logic [W-1:0] data;
  logic full;
  logic arrived;
  logic overrun;
  modport hold (input word, word_valid, pop, output data, full, arrived, overrun);
  modport ctrl (output word, word_valid, pop, input data, full, arrived, overrun);
endinterface

// ### src/rx_hold_buffer.sv
// One-word receive holder with overrun detection.
// Assumes the shifter presents each received word for one cycle.
`timescale 1ns/1ps
module rx_hold_buffer (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  rx_word_if.hold link
);
  logic [$bits(link.data)-1:0] data;
  logic [$bits(link.data)-1:0] next_data;
  logic full;
  logic next_full;
  logic arrived;
  logic next_arrived;
  logic overrun;
  logic next_overrun;

  always_comb begin
    next_data = data;
    next_full = full;
    next_arrived = 1'b0;
    next_overrun = 1'b0;
    if (link.pop) begin
      next_full = 1'b0;
    end
    if (link.word_valid) begin
      next_data = link.word;
      next_full = 1'b1;
      next_arrived = 1'b1;
      // Unread word overwritten: reader was late
      next_overrun = full && !link.pop;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data <= '0;
      full <= 1'b0;
      arrived <= 1'b0;
      overrun <= 1'b0;
    end else begin
      data <= next_data;
      full <= next_full;
      arrived <= next_arrived;
      overrun <= next_overrun;
    end
  end

  assign link.data = data;
  assign link.full = full;
  assign link.arrived = arrived;
  assign link.overrun = overrun;
endmodule

// ### src/serial_pin_port.sv
// Port control for the three serial pins: clock, data out, data in.
// Assumes a same-clock register port, pads outside, a shifter on the serial side.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Direction bit 0 makes a pin input, 1 drives its output value.
// RULE2: Input buffer bit 1 lets the pin level be read, 0 blocks it.
// RULE3: Output pin with buffer enabled reads back its driven value.
// RULE4: Pull-up bit 0 disconnects the pull-up from the pin.
// RULE5: Only ports 9, A to E and G carry pull-up control.
// RULE6: Output stage bit 0 selects push-pull instead of open-drain.
// RULE7: Only ports 0 to 3 and C carry output stage selection.
// RULE8: Output value is set high before switching the pin to output.
// RULE9: Input pin with buffer disabled floats at high impedance.
// RULE10: Writing zero to the function register returns pins to port use.
// RULE11: Software starts reception in a fixed order, then reads control back.
// RULE12: Software stops reception, reads control back, then releases pins.
// RULE13: Software blocks interruptions around each dummy write in fast reception.
// RULE14: From the third fast reception on, dummy writes follow completion.
// RULE15: An unread received word overwritten by a new one flags overrun.
// RULE16: Software enables the three serial pins by setting bits 1 to 3.
// RULE17: Each per-pin control bit affects only its own pin.
module serial_pin_port #(
  parameter logic [4:0] CLK_PORT = 5'h0c,
  parameter logic [4:0] DOUT_PORT = 5'h0c,
  parameter logic [4:0] DIN_PORT = 5'h0c
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic [2:0] pad_in,
  output logic [2:0] pad_out,
  output logic [2:0] pad_oe_n_out,
  output logic [2:0] pullup_out,
  input wire logic shifter_clock_in,
  input wire logic shifter_data_in,
  output logic shifter_data_out,
  input wire logic [7:0] rx_word_in,
  input wire logic rx_word_valid_in
);
  localparam int NP = pin_port_pkg::NUM_PINS;
  localparam int DW = pin_port_pkg::DATA_W;
  localparam int IW = pin_port_pkg::IRQ_W;
  localparam logic [2:0] PULL_MASK = {pin_port_pkg::has_pullup(DIN_PORT),
    pin_port_pkg::has_pullup(DOUT_PORT), pin_port_pkg::has_pullup(CLK_PORT)};
  localparam logic [2:0] STAGE_MASK = {pin_port_pkg::has_stage_select(DIN_PORT),
    pin_port_pkg::has_stage_select(DOUT_PORT), pin_port_pkg::has_stage_select(CLK_PORT)};

  logic [2:0] dir, next_dir;
  logic [2:0] out_value, next_out_value;
  logic [2:0] ibuf, next_ibuf;
  logic [2:0] pull, next_pull;
  logic [2:0] stage, next_stage;
  logic [7:0] fn, next_fn;
  logic [1:0] status, next_status;
  logic [1:0] mask, next_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic [1:0] irq_set;
  logic [1:0] irq_clear;
  logic [2:0] sync1, sync2, sync3;
  logic [2:0] level, next_level;
  logic [2:0] pin_state;
  logic [2:0] next_pad_out, next_pad_oe_n, next_pullup;
  logic next_shifter_data;

  rx_word_if #(.W(DW)) rxl ();

  rx_hold_buffer u_hold (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .link(rxl.hold)
  );

  assign rxl.word = rx_word_in;
  assign rxl.word_valid = rx_word_valid_in;
  assign rxl.pop = rd_in && (addr_in == pin_port_pkg::ADDR_RX_DATA);

  // Pad inputs: three stages, a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      next_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : level[i];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      level <= 3'h0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
    end
  end

  // Register writes, status flags and read data
  always_comb begin
    next_dir = dir;
    next_out_value = out_value;
    next_ibuf = ibuf;
    next_pull = pull;
    next_stage = stage;
    next_fn = fn;
    next_mask = mask;
    irq_clear = 2'h0;
    if (wr_in) begin
      case (addr_in)
        pin_port_pkg::ADDR_DIR: next_dir = wdata_in[NP-1:0];
        pin_port_pkg::ADDR_OUT_VALUE: next_out_value = wdata_in[NP-1:0];
        pin_port_pkg::ADDR_IBUF: next_ibuf = wdata_in[NP-1:0];
        // RULE5: absent pull-ups
        pin_port_pkg::ADDR_PULLUP: next_pull = wdata_in[NP-1:0] & PULL_MASK;
        // RULE7: fixed stage elsewhere
        pin_port_pkg::ADDR_STAGE: next_stage = wdata_in[NP-1:0] & STAGE_MASK;
        // RULE10: zero releases pins
        pin_port_pkg::ADDR_FUNCTION: next_fn = wdata_in;
        pin_port_pkg::ADDR_IRQ_STATUS: irq_clear = wdata_in[IW-1:0];
        pin_port_pkg::ADDR_IRQ_MASK: next_mask = wdata_in[IW-1:0];
        default: ;
      endcase
    end
    irq_set = 2'h0;
    irq_set[pin_port_pkg::IRQ_RX_READY] = rxl.arrived;
    // RULE15: overrun flagged
    irq_set[pin_port_pkg::IRQ_OVERRUN] = rxl.overrun;
    // New event wins over a clear in the same cycle
    next_status = (status & ~irq_clear) | irq_set;
    next_irq = |(next_status & next_mask);
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        pin_port_pkg::ADDR_DIR: next_rdata = {{(DW-NP){1'b0}}, dir};
        pin_port_pkg::ADDR_OUT_VALUE: next_rdata = {{(DW-NP){1'b0}}, out_value};
        pin_port_pkg::ADDR_IBUF: next_rdata = {{(DW-NP){1'b0}}, ibuf};
        pin_port_pkg::ADDR_PULLUP: next_rdata = {{(DW-NP){1'b0}}, pull};
        pin_port_pkg::ADDR_STAGE: next_rdata = {{(DW-NP){1'b0}}, stage};
        pin_port_pkg::ADDR_FUNCTION: next_rdata = fn;
        pin_port_pkg::ADDR_PIN_STATE: next_rdata = {{(DW-NP){1'b0}}, pin_state};
        pin_port_pkg::ADDR_RX_DATA: next_rdata = rxl.data;
        pin_port_pkg::ADDR_IRQ_STATUS: next_rdata = {{(DW-IW){1'b0}}, status};
        pin_port_pkg::ADDR_IRQ_MASK: next_rdata = {{(DW-IW){1'b0}}, mask};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir <= pin_port_pkg::DIR_RST;
      out_value <= pin_port_pkg::OUT_VALUE_RST;
      ibuf <= pin_port_pkg::IBUF_RST;
      pull <= pin_port_pkg::PULLUP_RST;
      stage <= pin_port_pkg::STAGE_RST;
      fn <= pin_port_pkg::FUNCTION_RST;
      status <= pin_port_pkg::IRQ_RST;
      mask <= pin_port_pkg::IRQ_RST;
      rdata_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      dir <= next_dir;
      out_value <= next_out_value;
      ibuf <= next_ibuf;
      pull <= next_pull;
      stage <= next_stage;
      fn <= next_fn;
      status <= next_status;
      mask <= next_mask;
      rdata_out <= next_rdata;
      irq_out <= next_irq;
    end
  end

  // RULE17: one slice per pin
  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic serial;
    logic drive_req;
    logic value;
    logic drive;
    assign serial = fn[pin_port_pkg::FN_PIN_LSB + i];
    // RULE1: direction selects driving
    assign drive_req = serial ? (i != pin_port_pkg::PIN_DIN) : dir[i];
    // RULE8: drives the value already held
    assign value = !serial ? out_value[i] :
      ((i == pin_port_pkg::PIN_CLK) ? shifter_clock_in : shifter_data_in);
    // RULE6: open-drain releases a high
    assign drive = drive_req && !(stage[i] && value);
    assign next_pad_out[i] = value;
    assign next_pad_oe_n[i] = !drive;
    // RULE4: pull-up off when cleared
    // RULE9: floating input keeps no pull-up
    assign next_pullup[i] = pull[i] && !drive && (serial || dir[i] || ibuf[i]);
    // RULE2: buffer gates pin state
    // RULE3: output reads its driven value
    assign pin_state[i] = ibuf[i] && ((dir[i] && !serial) ? out_value[i] : level[i]);
  end

  // Data in pin feeds the shifter only while the serial function owns it
  assign next_shifter_data = fn[pin_port_pkg::FN_PIN_LSB + pin_port_pkg::PIN_DIN] &&
    level[pin_port_pkg::PIN_DIN];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_out <= 3'h0;
      pad_oe_n_out <= 3'h7;
      pullup_out <= 3'h0;
      shifter_data_out <= 1'b0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_n_out <= next_pad_oe_n;
      pullup_out <= next_pullup;
      shifter_data_out <= next_shifter_data;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_dir_drives: assert property ( // RULE1
    (!fn[1] && dir[0] && !stage[0]) |=> (!pad_oe_n_out[0] && pad_out[0] == $past(out_value[0])))
    else $error("output pin not driving its value");
  chk_ibuf_blocks: assert property ( // RULE2
    (rd_in && addr_in == pin_port_pkg::ADDR_PIN_STATE && ibuf == 3'h0) |=> rdata_out == 8'h00)
    else $error("pin state visible with buffers off");
  chk_output_readback: assert property ( // RULE3
    (rd_in && addr_in == pin_port_pkg::ADDR_PIN_STATE && ibuf[0] && dir[0] && !fn[1])
    |=> rdata_out[0] == $past(out_value[0]))
    else $error("output pin does not read back its value");
  chk_pullup_off: assert property ( // RULE4
    !pull[0] |=> !pullup_out[0])
    else $error("pull-up on while disabled");
  chk_pull_absent: assert property ( // RULE5
    (pull & ~PULL_MASK) == 3'h0)
    else $error("pull-up bit set on port without pull-up");
  chk_push_pull: assert property ( // RULE6
    (!fn[2] && dir[1] && !stage[1] && out_value[1]) |=> (!pad_oe_n_out[1] && pad_out[1]))
    else $error("push-pull pin not driving high");
  chk_stage_fixed: assert property ( // RULE7
    (stage & ~STAGE_MASK) == 3'h0)
    else $error("stage bit set on fixed-stage port");
  chk_high_on_switch: assert property ( // RULE8
    (wr_in && addr_in == pin_port_pkg::ADDR_DIR && wdata_in[1] && !dir[1] && out_value[1]
     && !stage[1] && !fn[2]) ##1 !wr_in |=> (pad_out[1] && !pad_oe_n_out[1]))
    else $error("pin did not leave input mode high");
  chk_float_hiz: assert property ( // RULE9
    (!fn[2] && !dir[1] && !ibuf[1]) |=> (pad_oe_n_out[1] && !pullup_out[1]))
    else $error("floating pin not at high impedance");
  chk_fn_release: assert property ( // RULE10
    (wr_in && addr_in == pin_port_pkg::ADDR_FUNCTION && wdata_in == 8'h00)
    |=> (fn == 8'h00) ##1 (pad_out == $past(out_value)))
    else $error("pins not returned to port use");
  chk_overrun_flag: assert property ( // RULE15
    (rx_word_valid_in && rxl.full && !rxl.pop) |-> ##2 status[pin_port_pkg::IRQ_OVERRUN])
    else $error("overrun not flagged");
  chk_pin_isolation: assert property ( // RULE17
    (wr_in && addr_in != pin_port_pkg::ADDR_DIR) |=> dir == $past(dir))
    else $error("direction changed by another write");
  chk_pin_state_in: assert property ( // RULE2
    (rd_in && addr_in == pin_port_pkg::ADDR_PIN_STATE && ibuf[2] && !dir[2])
    |=> rdata_out[2] == $past(level[2]))
    else $error("input pin state not the filtered level");
  chk_pullup_pins: assert property ( // RULE5
    (pullup_out & ~PULL_MASK) == 3'h0)
    else $error("pull-up driven on port without pull-up");
  chk_open_drain_high: assert property ( // RULE6
    (!fn[2] && dir[1] && stage[1] && out_value[1]) |=> pad_oe_n_out[1])
    else $error("open-drain pin drives a high");
  chk_clk_serial: assert property ( // RULE16
    (fn[1] && !stage[0]) |=> (!pad_oe_n_out[0] && pad_out[0] == $past(shifter_clock_in)))
    else $error("serial clock not on clock pin");
  chk_din_undriven: assert property ( // RULE16
    fn[3] |=> pad_oe_n_out[2])
    else $error("serial data in pin driven");
  // Status flags are sticky; an event beats a clear in the same cycle
  chk_status_sticky: assert property ( // RULE15
    (status[pin_port_pkg::IRQ_OVERRUN] && !(wr_in && addr_in == pin_port_pkg::ADDR_IRQ_STATUS
     && wdata_in[pin_port_pkg::IRQ_OVERRUN])) |=> status[pin_port_pkg::IRQ_OVERRUN])
    else $error("overrun flag lost without clear");
  chk_set_wins: assert property ( // RULE15
    (rxl.arrived && wr_in && addr_in == pin_port_pkg::ADDR_IRQ_STATUS
     && wdata_in[pin_port_pkg::IRQ_RX_READY]) |=> status[pin_port_pkg::IRQ_RX_READY])
    else $error("clear beat a new event");
  chk_irq_level: assert property ( // RULE15
    irq_out == |(status & mask))
    else $error("interrupt level not status and mask");

  cov_serial_enable: cover property (wr_in && addr_in == pin_port_pkg::ADDR_FUNCTION
    && wdata_in == 8'h0e);
  cov_overrun: cover property (rxl.overrun);
  cov_irq: cover property ($rose(irq_out));
  cov_float: cover property (pad_oe_n_out == 3'h7 && pullup_out == 3'h0 && fn == 8'h00);
  cov_set_wins: cover property (rxl.arrived && wr_in
    && addr_in == pin_port_pkg::ADDR_IRQ_STATUS);
endmodule

// ### testbench/serial_slave_model.sv
// Serial slave standing on the far side of the three pins.
// Assumes the bench resolves pin levels; clock idles high.
`timescale 1ns/1ps
module serial_slave_model #(
  parameter logic [7:0] RESP = 8'h3c
) (
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [7:0] rx_byte_out
);
  logic [7:0] tx = RESP;
  initial miso_out = 1'b1;
  initial rx_byte_out = 8'h00;
  // Samples on the rising clock edge, most significant bit first
  always @(posedge sclk_in) begin
    rx_byte_out <= {rx_byte_out[6:0], mosi_in};
  end
  // Launches on the falling edge so the bit is settled at sampling
  always @(negedge sclk_in) begin
    miso_out <= tx[7];
    tx <= {tx[6:0], tx[7]};
  end
endmodule

// ### testbench/serial_pin_port_tb.sv
// Self-checking bench for the serial pin port control block.
// Assumes a board pull-up on the clock line and a slave on the data pins.
`timescale 1ns/1ps
module serial_pin_port_tb;
  logic sys_clk_in, reset_n_in, wr, rd, sclk, sdat, rxv, flt, miso, irq, sdo;
  logic [7:0] addr, wdata, rdata, rxw, slave_rx, got;
  logic [2:0] pad_in, pad_out, oe_n, pull;
  int err_count, tests_run;
  // Undriven data out pin without pull-up changes every cycle
  assign pad_in[0] = !oe_n[0] ? pad_out[0] : 1'b1;
  assign pad_in[1] = !oe_n[1] ? pad_out[1] : (pull[1] ? 1'b1 : flt);
  assign pad_in[2] = !oe_n[2] ? pad_out[2] : miso;

  // Data in pin on a port with neither pull-up nor stage select
  serial_pin_port #(.DIN_PORT(5'h05)) dut (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr),
    .wdata_in(wdata),
    .wr_in(wr),
    .rd_in(rd),
    .rdata_out(rdata),
    .irq_out(irq),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe_n_out(oe_n),
    .pullup_out(pull),
    .shifter_clock_in(sclk),
    .shifter_data_in(sdat),
    .shifter_data_out(sdo),
    .rx_word_in(rxw),
    .rx_word_valid_in(rxv)
  );

  serial_slave_model slave (
    .sclk_in(pad_in[0]),
    .mosi_in(pad_in[1]),
    .miso_out(miso),
    .rx_byte_out(slave_rx)
  );

  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge sys_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1;
    chk(rdata, e, what);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 20) begin
      cycles(1);
      n++;
    end
    if (n == 20) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic test_reset();
    chk({5'h00, oe_n}, 8'h07, "pins float after reset");
    chk({5'h00, pull}, 8'h00, "no pull-up after reset");
    rd_chk(pin_port_pkg::ADDR_DIR, 8'h00, "dir reset");
    rd_chk(pin_port_pkg::ADDR_OUT_VALUE, 8'h07, "value reset");
    rd_chk(pin_port_pkg::ADDR_FUNCTION, 8'h00, "function reset");
    rd_chk(8'h3c, 8'h00, "unmapped read");
  endtask

  task automatic test_port();
    wr_reg(pin_port_pkg::ADDR_DIR, 8'h02);
    cycles(2);
    chk({5'h00, oe_n}, 8'h05, "only data out drives");
    chk({7'h00, pad_out[1]}, 8'h01, "leaves input high");
    wr_reg(pin_port_pkg::ADDR_OUT_VALUE, 8'h05);
    cycles(2);
    chk({7'h00, pad_out[1]}, 8'h00, "drives low");
    wr_reg(pin_port_pkg::ADDR_PULLUP, 8'h07);
    wr_reg(pin_port_pkg::ADDR_IBUF, 8'h07);
    cycles(6);
    chk({5'h00, pull}, 8'h01, "pull-up off on driver");
    rd_chk(pin_port_pkg::ADDR_PIN_STATE, 8'h05, "output reads value");
    wr_reg(pin_port_pkg::ADDR_PULLUP, 8'h06);
    cycles(2);
    chk({5'h00, pull}, 8'h00, "pull-up off");
    rd_chk(pin_port_pkg::ADDR_PULLUP, 8'h02, "absent pull-up forced off");
    wr_reg(pin_port_pkg::ADDR_STAGE, 8'h06);
    cycles(2);
    chk({5'h00, oe_n}, 8'h05, "open drain low drives");
    wr_reg(pin_port_pkg::ADDR_OUT_VALUE, 8'h07);
    cycles(2);
    chk({5'h00, oe_n}, 8'h07, "open drain high floats");
    rd_chk(pin_port_pkg::ADDR_STAGE, 8'h02, "stage kept");
    wr_reg(pin_port_pkg::ADDR_STAGE, 8'h00);
    cycles(2);
    chk({5'h00, oe_n}, 8'h05, "push-pull high drives");
    wr_reg(pin_port_pkg::ADDR_IBUF, 8'h00);
    wr_reg(pin_port_pkg::ADDR_DIR, 8'h00);
    cycles(2);
    rd_chk(pin_port_pkg::ADDR_PIN_STATE, 8'h00, "buffer off reads 0");
    chk({5'h00, pull}, 8'h00, "floating drops pull-up");
    chk({5'h00, oe_n}, 8'h07, "floating pins");
  endtask

  task automatic test_serial();
    wr_reg(pin_port_pkg::ADDR_DIR, 8'h03);
    wr_reg(pin_port_pkg::ADDR_IRQ_STATUS, 8'h03);
    wr_reg(pin_port_pkg::ADDR_FUNCTION, 8'h0e);
    cycles(2);
    chk({5'h00, oe_n}, 8'h04, "serial takes pins");
    @(posedge sys_clk_in);
    for (int i = 7; i >= 0; i--) begin
      sdat <= 1'(8'ha6 >> i);
      sclk <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
      sclk <= 1'b1;
      cycles(8);
      got[i] = sdo;
      @(posedge sys_clk_in);
    end
    chk(got, 8'h3c, "word from slave");
    chk(slave_rx, 8'ha6, "word to slave");
    wr_reg(pin_port_pkg::ADDR_FUNCTION, 8'h00);
    cycles(2);
    chk({5'h00, oe_n}, 8'h04, "port settings again");
    chk({6'h00, pad_out[1:0]}, 8'h03, "port values again");
    wr_reg(pin_port_pkg::ADDR_DIR, 8'h00);
  endtask

  task automatic test_irq();
    wr_reg(pin_port_pkg::ADDR_IRQ_MASK, 8'h03);
    // a word follows only a completed reception
    @(posedge sys_clk_in);
    rxw <= 8'h5a;
    rxv <= 1'b1;
    @(posedge sys_clk_in);
    rxv <= 1'b0;
    // Clear lands with the arrival; the new event must win
    wr <= 1'b1;
    addr <= pin_port_pkg::ADDR_IRQ_STATUS;
    wdata <= 8'h01;
    @(posedge sys_clk_in);
    wr <= 1'b0;
    wait_irq(1'b1);
    rd_chk(pin_port_pkg::ADDR_IRQ_STATUS, 8'h01, "one word no overrun");
    // word read before the next one arrives
    rd_chk(pin_port_pkg::ADDR_RX_DATA, 8'h5a, "word read");
    wr_reg(pin_port_pkg::ADDR_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    @(posedge sys_clk_in);
    rxw <= 8'h11;
    rxv <= 1'b1;
    @(posedge sys_clk_in);
    rxw <= 8'h22;
    @(posedge sys_clk_in);
    rxv <= 1'b0;
    cycles(4);
    rd_chk(pin_port_pkg::ADDR_IRQ_STATUS, 8'h03, "unread word overrun");
    wr_reg(pin_port_pkg::ADDR_IRQ_MASK, 8'h00);
    wait_irq(1'b0);
    wr_reg(pin_port_pkg::ADDR_IRQ_MASK, 8'h02);
    wait_irq(1'b1);
    wr_reg(pin_port_pkg::ADDR_IRQ_STATUS, 8'h03);
    wait_irq(1'b0);
    rd_chk(pin_port_pkg::ADDR_IRQ_STATUS, 8'h00, "status cleared");
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) flt <= ~flt;

  initial begin
    {wr, rd, rxv, sdat, flt, reset_n_in} = '0;
    {addr, wdata, rxw} = '0;
    sclk = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    cycles(1);
    test_reset();
    test_port();
    test_serial();
    test_irq();
    final_report();
  end

  // Cuts a hang short
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule
